// file: rtl/gpio_portb_mux_input_qualifier.sv
`timescale 1ns/1ps
`default_nettype none

module gpio_portb_mux_input_qualifier #(
  parameter int unsigned PINS = gpio_portb_pkg::PIN_SLOTS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire gpio_portb_pkg::reg_req_type i_reg_req,
  output gpio_portb_pkg::periph_in_type o_periph_in,
  output logic [31:0] o_rd_data,
  output logic [PINS-1:0] o_pin_out,
  output logic [PINS-1:0] o_pin_oe,
  input wire logic [PINS-1:0] i_pin_in,
  input wire gpio_portb_pkg::periph_out_type i_periph_out,
  input wire gpio_portb_pkg::porta_offer_type i_porta_offer
);

  typedef struct packed {
    logic [31:0] port_control_reg;
    logic [31:0] input_qualify_select;
    logic [31:0] port_b_function_select;
    logic [31:0] direction;
    logic [31:0] port_data_reg;
    logic [gpio_portb_pkg::GROUPS-1:0][gpio_portb_pkg::CNT_W-1:0] count;
    logic [gpio_portb_pkg::GROUPS-1:0] sample_en;
    logic [31:0] rd_data;
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe;
    gpio_portb_pkg::periph_in_type periph_in;
  } top_state_type;

  top_state_type state_ff;
  top_state_type nxt_state;
  logic [PINS-1:0] qualified;
  logic [PINS-1:0] drv_out;
  logic [PINS-1:0] drv_oe;
  gpio_portb_pkg::periph_in_type from_b;
  gpio_portb_pkg::periph_in_type sel_b;

  // ****************************************
  // Register access helpers
  // ****************************************
  // Hit on the 32-bit pair whichever half the 16-bit address names
  function automatic logic hits(input logic [15:0] addr, input logic [15:0] ofs);
    hits = (addr[15:1] == ofs[15:1]);
  endfunction

  // Merge a write of either width into one register image
  function automatic logic [31:0] merge(input logic [31:0] old,
      input gpio_portb_pkg::reg_req_type req, input logic [31:0] mask);
    logic [31:0] img;
    img = old;
    if (req.acc32) begin
      img = req.wdata;
    end else if (req.addr[0]) begin
      img[31:16] = req.wdata[15:0];
    end else begin
      img[15:0] = req.wdata[15:0];
    end
    merge = img & mask;
  endfunction

  function automatic logic [31:0] pick(input logic [31:0] img,
      input gpio_portb_pkg::reg_req_type req);
    logic [31:0] val;
    val = img;
    if (!req.acc32) begin
      val = req.addr[0] ? {16'h0000, img[31:16]} : {16'h0000, img[15:0]};
    end
    pick = val;
  endfunction

  // ****************************************
  // Per-pin qualifiers
  // ****************************************
  // Each pin takes its group's strobe: pins 32-39 group 0, 40-42 group 1
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    input_qualifier u_qual (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_pin(i_pin_in[p]),
      .i_mode(state_ff.input_qualify_select[2*p +: 2]),
      .i_sample_en(state_ff.sample_en[p / gpio_portb_pkg::GROUP_SIZE]),
      .o_value(qualified[p])
    );
  end

  // ****************************************
  // Pin drive per function code
  // ****************************************
  // Reserved codes release the pin; the absent slot is never driven
  always_comb begin
    logic [1:0] fs;
    fs = gpio_portb_pkg::FUNC_GPIO;
    drv_out = '0;
    drv_oe = '0;
    for (int p = 0; p < PINS; p++) begin
      fs = state_ff.port_b_function_select[2*p +: 2];
      if (fs == gpio_portb_pkg::FUNC_GPIO && p != gpio_portb_pkg::ABSENT_SLOT) begin
        drv_out[p] = state_ff.port_data_reg[p];
        drv_oe[p] = state_ff.direction[p];
      end
    end
    unique case (state_ff.port_b_function_select[1:0])
      gpio_portb_pkg::FUNC_SEL1: drv_oe[0] = ~i_periph_out.i2c_data_line;
      gpio_portb_pkg::FUNC_SEL3: begin
        drv_out[0] = i_periph_out.encoder_strobe;
        drv_oe[0] = i_periph_out.encoder_strobe_oe;
      end
      default: ;
    endcase
    unique case (state_ff.port_b_function_select[3:2])
      gpio_portb_pkg::FUNC_SEL1: drv_oe[1] = ~i_periph_out.i2c_clock_line;
      gpio_portb_pkg::FUNC_SEL2: begin
        drv_out[1] = i_periph_out.pwm_sync_output;
        drv_oe[1] = 1'b1;
      end
      gpio_portb_pkg::FUNC_SEL3: begin
        drv_out[1] = i_periph_out.encoder_index;
        drv_oe[1] = i_periph_out.encoder_index_oe;
      end
      default: ;
    endcase
    if (state_ff.port_b_function_select[5:4] == gpio_portb_pkg::FUNC_SEL3) begin
      drv_out[2] = i_periph_out.pfc_comparator_trip_out;
      drv_oe[2] = 1'b1;
    end
    // Slots 3-6 keep only the GPIO drive set above
    if (state_ff.port_b_function_select[15:14] == gpio_portb_pkg::FUNC_SEL3) begin
      drv_out[7] = i_periph_out.pfc_comparator_trip_out;
      drv_oe[7] = 1'b1;
    end
    if (state_ff.port_b_function_select[17:16] == gpio_portb_pkg::FUNC_SEL1) begin
      drv_out[8] = i_periph_out.pwm7_out_a;
      drv_oe[8] = 1'b1;
    end
    unique case (state_ff.port_b_function_select[21:20])
      gpio_portb_pkg::FUNC_SEL1: begin
        drv_out[10] = i_periph_out.pwm7_out_b;
        drv_oe[10] = 1'b1;
      end
      gpio_portb_pkg::FUNC_SEL2: begin
        drv_out[10] = i_periph_out.uart3_transmit;
        drv_oe[10] = 1'b1;
      end
      gpio_portb_pkg::FUNC_SEL3: begin
        drv_out[10] = i_periph_out.motor_comparator_trip_out;
        drv_oe[10] = 1'b1;
      end
      default: ;
    endcase
  end

  // ****************************************
  // Peripheral input routing
  // ****************************************
  // Candidates offered by this port
  always_comb begin
    sel_b.i2c_data_line = state_ff.port_b_function_select[1:0] == gpio_portb_pkg::FUNC_SEL1;
    sel_b.i2c_clock_line = state_ff.port_b_function_select[3:2] == gpio_portb_pkg::FUNC_SEL1;
    sel_b.pwm_sync_input = state_ff.port_b_function_select[1:0] == gpio_portb_pkg::FUNC_SEL2;
    sel_b.encoder_strobe = state_ff.port_b_function_select[1:0] == gpio_portb_pkg::FUNC_SEL3;
    sel_b.encoder_index = state_ff.port_b_function_select[3:2] == gpio_portb_pkg::FUNC_SEL3;
    sel_b.uart3_receive = state_ff.port_b_function_select[15:14] == gpio_portb_pkg::FUNC_SEL2;
    from_b.i2c_data_line = qualified[0];
    from_b.i2c_clock_line = qualified[1];
    from_b.pwm_sync_input = qualified[0];
    from_b.encoder_strobe = qualified[0];
    from_b.encoder_index = qualified[1];
    from_b.uart3_receive = qualified[7];
  end

  // Lower port wins when both ports select the same input; neither gives idle
  function automatic logic route(input logic sel_a, input logic val_a,
      input logic sel_b, input logic val_b, input logic idle);
    route = sel_a ? val_a : (sel_b ? val_b : idle);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [gpio_portb_pkg::CNT_W-1:0] last;
    logic [gpio_portb_pkg::PERIOD_W-1:0] period;
    last = '0;
    period = '0;
    nxt_state = state_ff;

    // Sample strobe per group of eight: period 0 samples every clock,
    // otherwise once every 2 x period clocks
    for (int g = 0; g < gpio_portb_pkg::GROUPS; g++) begin
      period = state_ff.port_control_reg[g*gpio_portb_pkg::PERIOD_W +: gpio_portb_pkg::PERIOD_W];
      last = (period == '0) ? '0 : gpio_portb_pkg::CNT_W'({period, 1'b0} - 9'h001);
      if (state_ff.count[g] >= last) begin
        nxt_state.count[g] = '0;
        nxt_state.sample_en[g] = 1'b1;
      end else begin
        nxt_state.count[g] = state_ff.count[g] + 9'h001;
        nxt_state.sample_en[g] = 1'b0;
      end
    end

    // Register writes, masked to implemented fields
    if (i_reg_req.wr) begin
      if (hits(i_reg_req.addr, gpio_portb_pkg::PORT_CONTROL_OFS)) begin
        nxt_state.port_control_reg = merge(state_ff.port_control_reg, i_reg_req,
            gpio_portb_pkg::PORT_CONTROL_MASK);
      end
      if (hits(i_reg_req.addr, gpio_portb_pkg::QUALIFY_SEL_OFS)) begin
        nxt_state.input_qualify_select = merge(state_ff.input_qualify_select, i_reg_req,
            gpio_portb_pkg::FIELD_MASK);
      end
      if (hits(i_reg_req.addr, gpio_portb_pkg::FUNC_SEL_OFS)) begin
        nxt_state.port_b_function_select = merge(state_ff.port_b_function_select, i_reg_req,
            gpio_portb_pkg::FIELD_MASK);
      end
      if (hits(i_reg_req.addr, gpio_portb_pkg::DIRECTION_OFS)) begin
        nxt_state.direction = merge(state_ff.direction, i_reg_req, gpio_portb_pkg::PIN_MASK);
      end
      if (hits(i_reg_req.addr, gpio_portb_pkg::PORT_DATA_OFS)) begin
        nxt_state.port_data_reg = merge(state_ff.port_data_reg, i_reg_req,
            gpio_portb_pkg::PIN_MASK);
      end
    end

    // Reads answer one clock later; unmapped addresses read zero
    nxt_state.rd_data = '0;
    if (i_reg_req.rd) begin
      if (hits(i_reg_req.addr, gpio_portb_pkg::PORT_CONTROL_OFS)) begin
        nxt_state.rd_data = pick(state_ff.port_control_reg, i_reg_req);
      end else if (hits(i_reg_req.addr, gpio_portb_pkg::QUALIFY_SEL_OFS)) begin
        nxt_state.rd_data = pick(state_ff.input_qualify_select, i_reg_req);
      end else if (hits(i_reg_req.addr, gpio_portb_pkg::FUNC_SEL_OFS)) begin
        nxt_state.rd_data = pick(state_ff.port_b_function_select, i_reg_req);
      end else if (hits(i_reg_req.addr, gpio_portb_pkg::DIRECTION_OFS)) begin
        nxt_state.rd_data = pick(state_ff.direction, i_reg_req);
      end else if (hits(i_reg_req.addr, gpio_portb_pkg::PORT_DATA_OFS)) begin
        // Same address as the latch, but software sees the pins
        nxt_state.rd_data = pick(32'(qualified) & gpio_portb_pkg::PIN_MASK,
            i_reg_req);
      end
    end

    // Outputs leave through flops, costing one clock of latency
    nxt_state.pin_out = drv_out;
    nxt_state.pin_oe = drv_oe;
    nxt_state.periph_in.i2c_data_line = route(i_porta_offer.sel.i2c_data_line,
        i_porta_offer.val.i2c_data_line, sel_b.i2c_data_line, from_b.i2c_data_line,
        gpio_portb_pkg::IDLE_I2C);
    nxt_state.periph_in.i2c_clock_line = route(i_porta_offer.sel.i2c_clock_line,
        i_porta_offer.val.i2c_clock_line, sel_b.i2c_clock_line, from_b.i2c_clock_line,
        gpio_portb_pkg::IDLE_I2C);
    nxt_state.periph_in.pwm_sync_input = route(i_porta_offer.sel.pwm_sync_input,
        i_porta_offer.val.pwm_sync_input, sel_b.pwm_sync_input, from_b.pwm_sync_input,
        gpio_portb_pkg::IDLE_LOW);
    nxt_state.periph_in.encoder_strobe = route(i_porta_offer.sel.encoder_strobe,
        i_porta_offer.val.encoder_strobe, sel_b.encoder_strobe, from_b.encoder_strobe,
        gpio_portb_pkg::IDLE_LOW);
    nxt_state.periph_in.encoder_index = route(i_porta_offer.sel.encoder_index,
        i_porta_offer.val.encoder_index, sel_b.encoder_index, from_b.encoder_index,
        gpio_portb_pkg::IDLE_LOW);
    nxt_state.periph_in.uart3_receive = route(i_porta_offer.sel.uart3_receive,
        i_porta_offer.val.uart3_receive, sel_b.uart3_receive, from_b.uart3_receive,
        gpio_portb_pkg::IDLE_UART);
  end

  // ****************************************
  // State register
  // ****************************************
  // All selects clear on reset, so every pin starts as a synchronised GPIO input
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= '0;
      state_ff.port_control_reg <= gpio_portb_pkg::REG_RESET;
      state_ff.periph_in.i2c_data_line <= gpio_portb_pkg::IDLE_I2C;
      state_ff.periph_in.i2c_clock_line <= gpio_portb_pkg::IDLE_I2C;
      state_ff.periph_in.uart3_receive <= gpio_portb_pkg::IDLE_UART;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_periph_in = state_ff.periph_in;
  assign o_rd_data = state_ff.rd_data;
  assign o_pin_out = state_ff.pin_out;
  assign o_pin_oe = state_ff.pin_oe;

endmodule

`default_nettype wire

// file: rtl/gpio_portb_pkg.sv
package gpio_portb_pkg;

  // ****************************************
  // Port shape
  // ****************************************
  // Slot 9 of the upper port has no pin behind it; ten live pins here plus
  // thirty-two on the lower port make forty-two in all
  localparam int unsigned PIN_SLOTS = 11;
  localparam int unsigned ABSENT_SLOT = 9;
  localparam int unsigned GROUP_SIZE = 8;
  localparam int unsigned GROUPS = 2;
  localparam int unsigned PERIOD_W = 8;
  localparam int unsigned CNT_W = 9;
  localparam int unsigned WIN_DEPTH = 6;
  localparam int unsigned WIN_SHORT = 3;

  // ****************************************
  // Register offsets (16-bit word index) and implemented bits
  // ****************************************
  localparam logic [15:0] PORT_CONTROL_OFS = 16'h0010;
  localparam logic [15:0] QUALIFY_SEL_OFS = 16'h0012;
  localparam logic [15:0] FUNC_SEL_OFS = 16'h0016;
  localparam logic [15:0] DIRECTION_OFS = 16'h001a;
  localparam logic [15:0] PORT_DATA_OFS = 16'h0048;
  localparam logic [31:0] PORT_CONTROL_MASK = 32'h0000ffff;
  // Fields of pins 32-40 and 42; bits 19:18 have no pin behind them
  localparam logic [31:0] FIELD_MASK = 32'h0033ffff;
  localparam logic [31:0] PIN_MASK = 32'h000005ff;
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [1:0] FUNC_GPIO = 2'h0;
  localparam logic [1:0] FUNC_SEL1 = 2'h1;
  localparam logic [1:0] FUNC_SEL2 = 2'h2;
  localparam logic [1:0] FUNC_SEL3 = 2'h3;
  localparam logic [1:0] QUAL_SYNC = 2'h0;
  localparam logic [1:0] QUAL_WIN3 = 2'h1;
  localparam logic [1:0] QUAL_WIN6 = 2'h2;
  localparam logic [1:0] QUAL_ASYNC = 2'h3;

  // Idle levels of peripheral inputs with no pin selected
  localparam logic IDLE_I2C = 1'b1;
  localparam logic IDLE_UART = 1'b1;
  localparam logic IDLE_LOW = 1'b0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic acc32;
    logic [31:0] wdata;
  } reg_req_type;

  // Peripheral drive toward the pins
  typedef struct packed {
    logic i2c_data_line;
    logic i2c_clock_line;
    logic pwm_sync_output;
    logic encoder_strobe;
    logic encoder_strobe_oe;
    logic encoder_index;
    logic encoder_index_oe;
    logic pfc_comparator_trip_out;
    logic motor_comparator_trip_out;
    logic uart3_transmit;
    logic pwm7_out_a;
    logic pwm7_out_b;
  } periph_out_type;

  // Pin-derived inputs delivered to the peripherals
  typedef struct packed {
    logic i2c_data_line;
    logic i2c_clock_line;
    logic pwm_sync_input;
    logic encoder_strobe;
    logic encoder_index;
    logic uart3_receive;
  } periph_in_type;

  // Same inputs as offered by the lower port, each with its select flag
  typedef struct packed {
    periph_in_type sel;
    periph_in_type val;
  } porta_offer_type;

endpackage

// file: rtl/input_qualifier.sv
`timescale 1ns/1ps
`default_nettype none

module input_qualifier (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic [1:0] i_mode,
  input wire logic i_sample_en,
  output logic o_value
);

  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic [gpio_portb_pkg::WIN_DEPTH-1:0] window;
    logic qual;
  } qual_state_type;

  qual_state_type state_ff;
  qual_state_type nxt_state;
  logic [gpio_portb_pkg::WIN_DEPTH-1:0] shifted;
  logic [gpio_portb_pkg::WIN_SHORT-1:0] short_win;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync_a = i_pin;
    nxt_state.sync_b = state_ff.sync_a;
    shifted = {state_ff.window[gpio_portb_pkg::WIN_DEPTH-2:0], state_ff.sync_b};
    short_win = shifted[gpio_portb_pkg::WIN_SHORT-1:0];
    // Window fills only on the group's sample strobe, after the synchroniser
    if (i_sample_en) begin
      nxt_state.window = shifted;
      if (i_mode == gpio_portb_pkg::QUAL_WIN3) begin
        if (&short_win) begin
          nxt_state.qual = 1'b1;
        end else if (~|short_win) begin
          nxt_state.qual = 1'b0;
        end
      end else if (i_mode == gpio_portb_pkg::QUAL_WIN6) begin
        if (&shifted) begin
          nxt_state.qual = 1'b1;
        end else if (~|shifted) begin
          nxt_state.qual = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Mode select
  // ****************************************
  // Raw pass-through trusts the peripheral to synchronise on its own
  always_comb begin
    unique case (i_mode)
      gpio_portb_pkg::QUAL_SYNC: o_value = state_ff.sync_b;
      gpio_portb_pkg::QUAL_ASYNC: o_value = i_pin;
      default: o_value = state_ff.qual;
    endcase
  end

endmodule

`default_nettype wire

// file: sim/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Peripheral side of the mux
// ****
module periph_model (
  input wire logic i_sys_clk,
  input wire logic i_step,
  output gpio_portb_pkg::periph_out_type o_periph_out
);
  // Fresh drive levels just after an edge; a scrambler flips many bits per step
  initial o_periph_out = 12'h5a5;
  always @(posedge i_sys_clk) begin
    if (i_step) begin
      o_periph_out <= 12'(o_periph_out * 12'h005 + 12'h03b);
    end
  end
endmodule
`default_nettype wire

// file: sim/gpio_portb_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks of the upper port mux
// ****
module gpio_portb_props #(
  parameter int unsigned PINS = 11
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire gpio_portb_pkg::reg_req_type i_reg_req,
  input wire gpio_portb_pkg::periph_in_type o_periph_in,
  input wire logic [31:0] o_rd_data,
  input wire logic [PINS-1:0] o_pin_out,
  input wire logic [PINS-1:0] o_pin_oe,
  input wire gpio_portb_pkg::periph_out_type i_periph_out
);
  logic [31:0] fsel_ff;
  logic [31:0] nxt_fsel;
  logic hit;
  // Shadow of the function select, same edge as the device copy
  always_comb begin
    hit = i_reg_req.wr && (i_reg_req.addr[15:1] == gpio_portb_pkg::FUNC_SEL_OFS[15:1]);
    nxt_fsel = fsel_ff;
    if (hit && i_reg_req.acc32) begin
      nxt_fsel = i_reg_req.wdata;
    end else if (hit && i_reg_req.addr[0]) begin
      nxt_fsel[31:16] = i_reg_req.wdata[15:0];
    end else if (hit) begin
      nxt_fsel[15:0] = i_reg_req.wdata[15:0];
    end
  end
  // Shadow register
  always_ff @(posedge i_sys_clk) begin
    fsel_ff <= i_rst ? 32'h0 : nxt_fsel;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Pins lag the select and the peripheral level by one flop, hence $past
  property p_rdz; !$past(i_reg_req.rd) |-> o_rd_data == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("read data without read");
  property p_rst; $past(i_rst) |-> o_pin_oe == '0 && o_periph_in == 6'h31; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_abs; o_pin_oe[9] == 1'b0; endproperty
  a_abs: assert property (p_abs) else $error("absent slot driven");
  property p_od; $past(fsel_ff[1:0]) == 2'h1 |->
    !o_pin_out[0] && o_pin_oe[0] == !$past(i_periph_out.i2c_data_line); endproperty
  a_od: assert property (p_od) else $error("open drain data wrong");
  property p_sync; $past(fsel_ff[3:2]) == 2'h2 |->
    o_pin_oe[1] && o_pin_out[1] == $past(i_periph_out.pwm_sync_output); endproperty
  a_sync: assert property (p_sync) else $error("sync out wrong");
  property p_pfc; $past(fsel_ff[5:4]) == 2'h3 |->
    o_pin_oe[2] && o_pin_out[2] == $past(i_periph_out.pfc_comparator_trip_out); endproperty
  a_pfc: assert property (p_pfc) else $error("trip out wrong");
  property p_rsv; $past(fsel_ff[7:6]) != 2'h0 |-> !o_pin_oe[3]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code drove");
  property p_rx; $past(fsel_ff[15:14]) == 2'h2 |-> !o_pin_oe[7]; endproperty
  a_rx: assert property (p_rx) else $error("receive pin driven");
  property p_pwm; $past(fsel_ff[17:16]) == 2'h1 |->
    o_pin_oe[8] && o_pin_out[8] == $past(i_periph_out.pwm7_out_a); endproperty
  a_pwm: assert property (p_pwm) else $error("pwm a wrong");
  property p_mot; $past(fsel_ff[21:20]) == 2'h3 |->
    o_pin_oe[10] && o_pin_out[10] == $past(i_periph_out.motor_comparator_trip_out); endproperty
  a_mot: assert property (p_mot) else $error("motor trip wrong");
  c_rd: cover property (i_reg_req.rd);
  c_od: cover property (fsel_ff[1:0] == 2'h1);
  c_mot: cover property (fsel_ff[21:20] == 2'h3);
endmodule
bind gpio_portb_mux_input_qualifier gpio_portb_props #(.PINS(PINS)) u_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_req(i_reg_req), .o_periph_in(o_periph_in),
  .o_rd_data(o_rd_data), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
  .i_periph_out(i_periph_out)
);
`default_nettype wire

// file: sim/gpio_portb_mux_input_qualifier_test.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_portb_mux_input_qualifier_test;
  logic clk;
  logic rst = 1'b1;
  logic step = 1'b0;
  logic [10:0] ext = '0;
  logic [10:0] pin_lvl;
  logic [10:0] oe;
  logic [10:0] po;
  logic [31:0] rdat;
  gpio_portb_pkg::reg_req_type req = '0;
  gpio_portb_pkg::periph_in_type pin_i;
  gpio_portb_pkg::periph_out_type pout;
  gpio_portb_pkg::porta_offer_type offer = '0;
  int num_errors = 0;
  int n_compared = 0;
  int lat_q[$] = '{3, 6, 9, 1};
  logic [15:0] ofs[4] = '{gpio_portb_pkg::PORT_CONTROL_OFS, gpio_portb_pkg::QUALIFY_SEL_OFS,
    gpio_portb_pkg::FUNC_SEL_OFS, gpio_portb_pkg::DIRECTION_OFS};
  logic [31:0] msk[4] = '{gpio_portb_pkg::PORT_CONTROL_MASK, gpio_portb_pkg::FIELD_MASK,
    gpio_portb_pkg::FIELD_MASK, gpio_portb_pkg::PIN_MASK};
  gpio_portb_mux_input_qualifier dut (
    .i_sys_clk(clk), .i_rst(rst), .i_reg_req(req), .o_periph_in(pin_i), .o_rd_data(rdat),
    .o_pin_out(po), .o_pin_oe(oe), .i_pin_in(pin_lvl), .i_periph_out(pout),
    .i_porta_offer(offer)
  );
  periph_model u_periph (.i_sys_clk(clk), .i_step(step), .o_periph_out(pout));
  // Wire level: a driven pin wins over the outside source
  assign pin_lvl = (oe & po) | (~oe & ext);
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held for one taking edge, answer sampled after it
  task automatic bus(input logic w, input logic h, input logic [15:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    req <= '{addr: a, rd: !w, wr: w, acc32: !h, wdata: d};
    @(posedge clk);
    req <= '0;
    #1 q = rdat;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, 1'b0, a, d, x);
  endtask
  // Expected {enables, levels} when every field holds code c
  function automatic logic [21:0] exp_drv(input logic [1:0] c,
    input gpio_portb_pkg::periph_out_type p);
    case (c)
      2'h1: exp_drv = {3'h5, 6'h0, !p.i2c_clock_line, !p.i2c_data_line,
        p.pwm7_out_b, 1'b0, p.pwm7_out_a, 8'h0};
      2'h2: exp_drv = {11'h402, p.uart3_transmit, 8'h0, p.pwm_sync_output, 1'b0};
      2'h3: exp_drv = {3'h4, 1'b1, 4'h0, 1'b1, p.encoder_index_oe, p.encoder_strobe_oe,
        p.motor_comparator_trip_out, 2'h0, p.pfc_comparator_trip_out, 4'h0,
        p.pfc_comparator_trip_out, p.encoder_index, p.encoder_strobe};
      default: exp_drv = '0;
    endcase
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, about twenty times the expected run
  initial begin
    #40000;
    num_errors++;
    give_verdict();
  end
  // ****
  // Tests
  // ****
  initial begin
    int n;
    int g;
    logic [31:0] d;
    logic [31:0] q;
    logic [21:0] e;
    void'($urandom(32'hcc2e5337));
    ext <= 11'($urandom());
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk("idle", 32'h31, 32'(pin_i));
    foreach (ofs[i]) begin
      d = $urandom();
      bus(1'b0, 1'b0, ofs[i], '0, q);
      chk("reset", '0, q);
      wr(ofs[i], d);
      bus(1'b1, 1'b1, ofs[i] | 16'h1, ~d, q);
      bus(1'b0, 1'b0, ofs[i], '0, q);
      chk("reg", {~d[15:0], d[15:0]} & msk[i], q);
      bus(1'b0, 1'b1, ofs[i] | 16'h1, '0, q);
      chk("half", {16'h0000, ~d[15:0] & msk[i][31:16]}, q);
      wr(ofs[i], '0);
    end
    wr(16'h0030, '1);
    bus(1'b0, 1'b0, 16'h0030, '0, q);
    chk("unmapped", '0, q);
    $display("registers done");
    for (int c = 0; c < 4; c++) begin
      wr(gpio_portb_pkg::FUNC_SEL_OFS, {16{2'(c)}});
      repeat (4) begin
        @(posedge clk);
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        repeat (3) @(posedge clk);
        e = exp_drv(2'(c), pout);
        chk("oe", 32'(e[21:11]), 32'(oe));
        chk("out", 32'(e[10:0] & e[21:11]), 32'(po & e[21:11]));
      end
    end
    $display("mux done");
    wr(gpio_portb_pkg::FUNC_SEL_OFS, '0);
    d = $urandom();
    wr(gpio_portb_pkg::PORT_DATA_OFS, d);
    wr(gpio_portb_pkg::DIRECTION_OFS, '1);
    repeat (3) @(posedge clk);
    chk("gpio oe", gpio_portb_pkg::PIN_MASK, 32'(oe));
    chk("gpio out", d & gpio_portb_pkg::PIN_MASK, 32'(po) & gpio_portb_pkg::PIN_MASK);
    wr(gpio_portb_pkg::DIRECTION_OFS, '0);
    ext <= 11'($urandom());
    repeat (6) @(posedge clk);
    bus(1'b0, 1'b0, gpio_portb_pkg::PORT_DATA_OFS, '0, q);
    chk("pins", 32'(ext) & gpio_portb_pkg::PIN_MASK, q);
    $display("data done");
    wr(gpio_portb_pkg::FUNC_SEL_OFS, 32'h8000);
    for (int m = 0; m < 5; m++) begin
      wr(gpio_portb_pkg::PORT_CONTROL_OFS, (m == 4) ? 32'h2 : 32'h0);
      wr(gpio_portb_pkg::QUALIFY_SEL_OFS, 32'((m == 4) ? 1 : m) << 14);
      @(posedge clk);
      ext[7] <= 1'b0;
      repeat (40) @(posedge clk);
      chk("low", '0, 32'(pin_i.uart3_receive));
      ext[7] <= 1'b1;
      n = 0;
      while (pin_i.uart3_receive !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1 n++;
      end
      if (m < 4) begin
        chk("delay", lat_q[m], n);
      end else begin
        chk("slow", 32'h1, 32'(n >= 12 && n <= 15));
      end
      if (m == 1 || m == 2) begin
        @(posedge clk);
        ext[7] <= 1'b0;
        repeat (3 * m - 1) @(posedge clk);
        ext[7] <= 1'b1;
        g = 0;
        repeat (15) begin
          @(posedge clk);
          #1 g += int'(pin_i.uart3_receive !== 1'b1);
        end
        chk("glitch", '0, g);
      end
    end
    offer.sel.uart3_receive <= 1'b1;
    offer.sel.encoder_strobe <= 1'b1;
    offer.val.encoder_strobe <= 1'b1;
    repeat (4) @(posedge clk);
    chk("offer", 32'h4, 32'(pin_i) & 32'h5);
    $display("qualify done");
    give_verdict();
  end
endmodule
`default_nettype wire
